// [design/etsr_pkg.sv]
// Package of offsets, field layouts and codes for the event timestamp sample registers
package etsr_pkg;
  localparam int ETSR_ADDR_W = 16;
  localparam int ETSR_DATA_W = 32;
  localparam int ETSR_NS_W = 30;
  localparam int ETSR_PHASE_W = 3;
  localparam int ETSR_CNT_W = 4;
  localparam int ETSR_NUM_SLOTS = 3;
  localparam int ETSR_NUM_UNITS = 2;

  localparam logic [15:0] ETSR_UNIT_INDEX_OFFSET = 16'h0540;
  localparam logic [15:0] ETSR_SAMPLE1_NS_OFFSET = 16'h0554;
  localparam logic [15:0] ETSR_SAMPLE1_SEC_OFFSET = 16'h0558;
  localparam logic [15:0] ETSR_SAMPLE1_PHASE_OFFSET = 16'h055c;
  localparam logic [15:0] ETSR_SAMPLE2_NS_OFFSET = 16'h0560;
  localparam logic [15:0] ETSR_SAMPLE2_SEC_OFFSET = 16'h0564;
  localparam logic [15:0] ETSR_SAMPLE2_PHASE_OFFSET = 16'h0568;
  localparam logic [15:0] ETSR_SAMPLE3_NS_OFFSET = 16'h056c;
  localparam logic [15:0] ETSR_SAMPLE3_SEC_OFFSET = 16'h0570;
  localparam logic [15:0] ETSR_SAMPLE3_PHASE_OFFSET = 16'h0574;

  localparam int ETSR_UNIT_PTR_BIT = 8;
  localparam int ETSR_EDGE_BIT = 30;
  localparam logic [31:0] ETSR_RESET_WORD = 32'h0000_0000;
  localparam logic [3:0] ETSR_CNT_MAX = 4'hf;
  localparam logic [3:0] ETSR_SLOTS_CNT = 4'h3;

  // One 40 ns period of the 25 MHz sampler holds five 8 ns sub-slots
  localparam int ETSR_SUB_SLOT_NS = 8;
  localparam int ETSR_PERIOD_NS = 40;
  localparam logic [2:0] ETSR_LAST_SUB_SLOT = 3'(ETSR_PERIOD_NS / ETSR_SUB_SLOT_NS - 1);

  localparam logic [2:0] ETSR_PHASE_0NS = 3'h0;
  localparam logic [2:0] ETSR_PHASE_8NS = 3'h1;
  localparam logic [2:0] ETSR_PHASE_16NS = 3'h2;
  localparam logic [2:0] ETSR_PHASE_24NS = 3'h3;
  localparam logic [2:0] ETSR_PHASE_32NS = 3'h4;

  // Sub-slot index to phase code; out-of-range slots clamp to the last code
  function automatic logic [2:0] etsr_phase_code(input logic [2:0] slot);
    case (slot)
      3'h0: etsr_phase_code = ETSR_PHASE_0NS;
      3'h1: etsr_phase_code = ETSR_PHASE_8NS;
      3'h2: etsr_phase_code = ETSR_PHASE_16NS;
      3'h3: etsr_phase_code = ETSR_PHASE_24NS;
      default: etsr_phase_code = ETSR_PHASE_32NS;
    endcase
  endfunction
endpackage

// [design/etsr_cap_if.sv]
// Interface carrying one capture unit's stored samples to the register file
`timescale 1ns/1ps
interface etsr_cap_if;
  import etsr_pkg::*;
  logic [31:0] sec [ETSR_NUM_SLOTS];
  logic [ETSR_NS_W-1:0] ns [ETSR_NUM_SLOTS];
  logic edge_pol [ETSR_NUM_SLOTS];
  logic [ETSR_PHASE_W-1:0] phase [ETSR_NUM_SLOTS];
  logic [ETSR_CNT_W-1:0] count;
  modport unit (output sec, output ns, output edge_pol, output phase, output count);
  modport regs (input sec, input ns, input edge_pol, input phase, input count);
endinterface

// [design/etsr_capture_unit.sv]
// One event timestamp input unit: edge detection, event count and sample slots
`timescale 1ns/1ps
module etsr_capture_unit
  import etsr_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic event_in,
  input wire logic [31:0] tod_seconds,
  input wire logic [ETSR_NS_W-1:0] tod_nanoseconds,
  input wire logic [2:0] tod_sub_slot,
  etsr_cap_if.unit cap
);
  logic prev_reg;
  logic [ETSR_CNT_W-1:0] count_reg;
  logic [31:0] sec_reg [ETSR_NUM_SLOTS];
  logic [ETSR_NS_W-1:0] ns_reg [ETSR_NUM_SLOTS];
  logic edge_reg [ETSR_NUM_SLOTS];
  logic [ETSR_PHASE_W-1:0] ph_reg [ETSR_NUM_SLOTS];

  wire rise = event_in & ~prev_reg;
  wire fall = ~event_in & prev_reg;
  wire hit = rise | fall;
  wire store = hit && (count_reg < ETSR_SLOTS_CNT);
  wire [1:0] slot = count_reg[1:0];
  wire [ETSR_CNT_W-1:0] count_next = (hit && count_reg != ETSR_CNT_MAX) ?
    4'(count_reg + 4'h1) : count_reg;
  wire [2:0] phase_next = etsr_phase_code(tod_sub_slot);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prev_reg <= 1'b0;
      count_reg <= '0;
    end
    else
    begin
      prev_reg <= event_in;
      count_reg <= count_next;
    end
  end

  // Slots fill in detection order; later events are only counted, until the count saturates at 15
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < ETSR_NUM_SLOTS; i++)
      begin
        sec_reg[i] <= '0;
        ns_reg[i] <= '0;
        edge_reg[i] <= 1'b0;
        ph_reg[i] <= '0;
      end
    end
    else if (store)
    begin
      sec_reg[slot] <= tod_seconds;
      ns_reg[slot] <= tod_nanoseconds;
      edge_reg[slot] <= rise;
      ph_reg[slot] <= phase_next;
    end
  end

  assign cap.sec = sec_reg;
  assign cap.ns = ns_reg;
  assign cap.edge_pol = edge_reg;
  assign cap.phase = ph_reg;
  assign cap.count = count_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_count_inc;
    hit && count_reg != ETSR_CNT_MAX |=> count_reg == 4'($past(count_reg) + 4'h1);
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("event count did not advance");

  property p_count_sat;
    count_reg == ETSR_CNT_MAX |=> count_reg == ETSR_CNT_MAX;
  endproperty
  a_count_sat: assert property (p_count_sat) else $error("event count left saturation");

  property p_first_rise;
    rise && count_reg == 4'h0 |=> edge_reg[0] && sec_reg[0] == $past(tod_seconds)
      && ns_reg[0] == $past(tod_nanoseconds);
  endproperty
  a_first_rise: assert property (p_first_rise) else $error("first rising sample wrong");

  property p_second_fall;
    fall && count_reg == 4'h1 |=> !edge_reg[1] && sec_reg[1] == $past(tod_seconds);
  endproperty
  a_second_fall: assert property (p_second_fall)
    else $error("second falling sample wrong");

  property p_phase_16;
    hit && count_reg == 4'h2 && tod_sub_slot == 3'h2 |=> ph_reg[2] == ETSR_PHASE_16NS;
  endproperty
  a_phase_16: assert property (p_phase_16) else $error("16 ns phase code wrong");

  property p_slots_held;
    count_reg >= ETSR_SLOTS_CNT |=> $stable(sec_reg[0]) && $stable(ns_reg[2])
      && $stable(ph_reg[1]);
  endproperty
  a_slots_held: assert property (p_slots_held)
    else $error("full slots were overwritten");
endmodule // etsr_capture_unit

// [design/etsr_sample_regs.sv]
// Register file of the event timestamp sample results, two units behind one pointer
`timescale 1ns/1ps
module etsr_sample_regs
  import etsr_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ETSR_NUM_UNITS-1:0] event_in,
  input wire logic [31:0] tod_seconds,
  input wire logic [ETSR_NS_W-1:0] tod_nanoseconds,
  input wire logic [2:0] tod_sub_slot,
  input wire logic [ETSR_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ETSR_DATA_W-1:0] reg_wdata,
  output logic [ETSR_DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  output logic unit_ptr
);
  logic unit_ptr_reg;
  logic [ETSR_DATA_W-1:0] rdata_reg;
  logic rvalid_reg;

  etsr_cap_if cap0 ();
  etsr_cap_if cap1 ();

  etsr_capture_unit u_unit0 (
    .clk(clk),
    .sys_rst(sys_rst),
    .event_in(event_in[0]),
    .tod_seconds(tod_seconds),
    .tod_nanoseconds(tod_nanoseconds),
    .tod_sub_slot(tod_sub_slot),
    .cap(cap0)
  );

  etsr_capture_unit u_unit1 (
    .clk(clk),
    .sys_rst(sys_rst),
    .event_in(event_in[1]),
    .tod_seconds(tod_seconds),
    .tod_nanoseconds(tod_nanoseconds),
    .tod_sub_slot(tod_sub_slot),
    .cap(cap1)
  );

  // Per-slot words of the selected unit
  logic [31:0] sel_sec [ETSR_NUM_SLOTS];
  logic [31:0] sel_ns_word [ETSR_NUM_SLOTS];
  logic [31:0] sel_ph_word [ETSR_NUM_SLOTS];

  for (genvar k = 0; k < ETSR_NUM_SLOTS; k++)
  begin : g_slot
    assign sel_sec[k] = unit_ptr_reg ? cap1.sec[k] : cap0.sec[k];
    assign sel_ns_word[k] = unit_ptr_reg ? {1'b0, cap1.edge_pol[k], cap1.ns[k]} :
      {1'b0, cap0.edge_pol[k], cap0.ns[k]};
    // Phase words are not pointer-indexed in the map, but follow the pointer so a
    // sample's three words always come from the same unit
    assign sel_ph_word[k] = {29'h0, unit_ptr_reg ? cap1.phase[k] : cap0.phase[k]};
  end

  wire hit_ptr = reg_addr == ETSR_UNIT_INDEX_OFFSET;
  wire hit_s1n = reg_addr == ETSR_SAMPLE1_NS_OFFSET;
  wire hit_s1s = reg_addr == ETSR_SAMPLE1_SEC_OFFSET;
  wire hit_s1p = reg_addr == ETSR_SAMPLE1_PHASE_OFFSET;
  wire hit_s2n = reg_addr == ETSR_SAMPLE2_NS_OFFSET;
  wire hit_s2s = reg_addr == ETSR_SAMPLE2_SEC_OFFSET;
  wire hit_s2p = reg_addr == ETSR_SAMPLE2_PHASE_OFFSET;
  wire hit_s3n = reg_addr == ETSR_SAMPLE3_NS_OFFSET;
  wire hit_s3s = reg_addr == ETSR_SAMPLE3_SEC_OFFSET;
  wire hit_s3p = reg_addr == ETSR_SAMPLE3_PHASE_OFFSET;
  wire hit_any = hit_ptr || hit_s1n || hit_s1s || hit_s1p || hit_s2n || hit_s2s || hit_s2p ||
    hit_s3n || hit_s3s || hit_s3p;

  wire [31:0] ptr_word = 32'(unit_ptr_reg) << ETSR_UNIT_PTR_BIT;

  // Unmapped addresses read as zero
  wire [31:0] rd_word =
    hit_ptr ? ptr_word :
    hit_s1n ? sel_ns_word[0] :
    hit_s1s ? sel_sec[0] :
    hit_s1p ? sel_ph_word[0] :
    hit_s2n ? sel_ns_word[1] :
    hit_s2s ? sel_sec[1] :
    hit_s2p ? sel_ph_word[1] :
    hit_s3n ? sel_ns_word[2] :
    hit_s3s ? sel_sec[2] :
    hit_s3p ? sel_ph_word[2] :
    ETSR_RESET_WORD;

  // Only the pointer register accepts writes; sample words have no write path
  wire ptr_next = (reg_wr && hit_ptr) ? reg_wdata[ETSR_UNIT_PTR_BIT] : unit_ptr_reg;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      unit_ptr_reg <= 1'b0;
      rdata_reg <= ETSR_RESET_WORD;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      unit_ptr_reg <= ptr_next;
      rdata_reg <= reg_rd ? rd_word : rdata_reg;
      rvalid_reg <= reg_rd;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign unit_ptr = unit_ptr_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_read_answer;
    reg_rd |=> reg_rvalid ##1 (!reg_rvalid || $past(reg_rd));
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer missing or stretched");

  property p_unit1_sec;
    reg_rd && hit_s2s && unit_ptr_reg |=> reg_rdata == $past(cap1.sec[1]);
  endproperty
  a_unit1_sec: assert property (p_unit1_sec) else $error("unit 1 seconds not selected");

  property p_unit0_ns;
    reg_rd && hit_s3n && !unit_ptr_reg |=> reg_rdata ==
      {1'b0, $past(cap0.edge_pol[2]), $past(cap0.ns[2])};
  endproperty
  a_unit0_ns: assert property (p_unit0_ns) else $error("unit 0 nanoseconds word wrong");

  property p_ns_top_zero;
    reg_rd && (hit_s1n || hit_s2n || hit_s3n) |=> !reg_rdata[31];
  endproperty
  a_ns_top_zero: assert property (p_ns_top_zero)
    else $error("nanoseconds bit 31 not zero");

  property p_phase_reserved;
    reg_rd && (hit_s1p || hit_s2p || hit_s3p) |=> reg_rdata[31:3] == 29'h0
      && reg_rdata[2:0] <= ETSR_LAST_SUB_SLOT;
  endproperty
  a_phase_reserved: assert property (p_phase_reserved)
    else $error("phase word out of range");

  property p_sample_write_ignored;
    reg_wr && !hit_ptr |=> $stable(unit_ptr_reg)
      && ($stable(cap0.sec[0]) || $changed(cap0.count));
  endproperty
  a_sample_write_ignored: assert property (p_sample_write_ignored)
    else $error("write altered state");

  property p_ptr_write;
    reg_wr && hit_ptr |=> unit_ptr_reg == $past(reg_wdata[ETSR_UNIT_PTR_BIT]);
  endproperty
  a_ptr_write: assert property (p_ptr_write) else $error("unit pointer not written");

  property p_rdata_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a read");

  property p_rvalid_source;
    reg_rvalid |-> $past(reg_rd);
  endproperty
  a_rvalid_source: assert property (p_rvalid_source) else $error("read answer without a read");

  property p_unit0_sec1;
    reg_rd && hit_s1s && !unit_ptr_reg |=> reg_rdata == $past(cap0.sec[0]);
  endproperty
  a_unit0_sec1: assert property (p_unit0_sec1)
    else $error("unit 0 first seconds wrong");

  property p_unit0_sec2;
    reg_rd && hit_s2s && !unit_ptr_reg |=> reg_rdata == $past(cap0.sec[1]);
  endproperty
  a_unit0_sec2: assert property (p_unit0_sec2)
    else $error("unit 0 second seconds wrong");

  property p_unit1_sec3;
    reg_rd && hit_s3s && unit_ptr_reg |=> reg_rdata == $past(cap1.sec[2]);
  endproperty
  a_unit1_sec3: assert property (p_unit1_sec3)
    else $error("unit 1 third seconds wrong");

  property p_unit0_ns1;
    reg_rd && hit_s1n && !unit_ptr_reg |=> reg_rdata ==
      {1'b0, $past(cap0.edge_pol[0]), $past(cap0.ns[0])};
  endproperty
  a_unit0_ns1: assert property (p_unit0_ns1)
    else $error("unit 0 first nanoseconds word wrong");

  property p_unit1_ns2;
    reg_rd && hit_s2n && unit_ptr_reg |=> reg_rdata ==
      {1'b0, $past(cap1.edge_pol[1]), $past(cap1.ns[1])};
  endproperty
  a_unit1_ns2: assert property (p_unit1_ns2)
    else $error("unit 1 second nanoseconds word wrong");

  property p_unit0_phase3;
    reg_rd && hit_s3p && !unit_ptr_reg |=> reg_rdata ==
      {29'h0, $past(cap0.phase[2])};
  endproperty
  a_unit0_phase3: assert property (p_unit0_phase3)
    else $error("unit 0 third phase wrong");

  property p_unit1_phase1;
    reg_rd && hit_s1p && unit_ptr_reg |=> reg_rdata ==
      {29'h0, $past(cap1.phase[0])};
  endproperty
  a_unit1_phase1: assert property (p_unit1_phase1)
    else $error("unit 1 first phase wrong");

  property p_ptr_readback;
    reg_rd && hit_ptr |=> reg_rdata ==
      {23'h0, $past(unit_ptr_reg), 8'h0};
  endproperty
  a_ptr_readback: assert property (p_ptr_readback)
    else $error("unit pointer read back wrong");

  property p_unmapped_zero;
    reg_rd && !hit_any |=> reg_rdata == ETSR_RESET_WORD;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_ptr_hold;
    !(reg_wr && hit_ptr) |=> $stable(unit_ptr_reg);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold)
    else $error("unit pointer moved without a write");
endmodule // etsr_sample_regs

// [test/etsr_sample_regs_tb_top.sv]
// Self-checking bench for the event timestamp sample result registers
`timescale 1ns/1ps
module etsr_sample_regs_tb_top;
  import etsr_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [ETSR_NUM_UNITS-1:0] event_in = '0;
  logic [31:0] tod_seconds = '0;
  logic [ETSR_NS_W-1:0] tod_nanoseconds = '0;
  logic [2:0] tod_sub_slot = '0;
  logic [ETSR_ADDR_W-1:0] reg_addr = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [ETSR_DATA_W-1:0] reg_wdata = '0;
  logic [ETSR_DATA_W-1:0] reg_rdata;
  logic reg_rvalid;
  logic unit_ptr;
  int bad_count = 0;
  int n_tests = 0;
  logic [31:0] first_word;

  always #2.5 clk = ~clk;

  etsr_sample_regs DUT (
    .clk(clk),
    .sys_rst(sys_rst),
    .event_in(event_in),
    .tod_seconds(tod_seconds),
    .tod_nanoseconds(tod_nanoseconds),
    .tod_sub_slot(tod_sub_slot),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .unit_ptr(unit_ptr)
  );

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // One read strobe; answer is checked 1 ns after the taking edge
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("rvalid", 32'h1, {31'h0, reg_rvalid});
    chk($sformatf("rdata at %h", a), exp, reg_rdata);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Time base is inverted after the taking edge so a late capture shows up
  task automatic ev(input int u, input logic lvl, input logic [31:0] s, input logic [29:0] n,
                    input logic [2:0] sl);
    @(posedge clk);
    event_in[u] <= lvl;
    tod_seconds <= s;
    tod_nanoseconds <= n;
    tod_sub_slot <= sl;
    @(posedge clk);
    tod_seconds <= ~s;
    tod_nanoseconds <= ~n;
    tod_sub_slot <= 3'h5;
  endtask

  task automatic slot(input int k, input logic [31:0] s, input logic [29:0] n, input logic p,
                      input logic [2:0] c);
    rd(16'(ETSR_SAMPLE1_NS_OFFSET + 12 * k), {1'b0, p, n});
    rd(16'(ETSR_SAMPLE1_SEC_OFFSET + 12 * k), s);
    rd(16'(ETSR_SAMPLE1_PHASE_OFFSET + 12 * k), {29'h0, c});
  endtask

  task automatic unit0_slots();
    slot(0, 32'h1234_5678, 30'h3fff_fff0, 1'b1, 3'h2);
    slot(1, 32'h1234_5679, 30'h0000_0010, 1'b0, 3'h1);
    slot(2, 32'hffff_ffff, 30'h2aaa_aaaa, 1'b1, 3'h4);
  endtask

  initial
  begin
    #20000;
    bad_count++;
    $display("unexpected run length: expected end, seen watchdog expiry");
    print_verdict();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk("unit_ptr", 32'h0, {31'h0, unit_ptr});
    for (int k = 0; k < 9; k++)
      rd(16'(ETSR_SAMPLE1_NS_OFFSET + 4 * k), ETSR_RESET_WORD);
    rd(ETSR_UNIT_INDEX_OFFSET, 32'h0);
    // Unit 0 sees four edges; only the first three are kept
    ev(0, 1'b1, 32'h1234_5678, 30'h3fff_fff0, 3'h2);
    ev(0, 1'b0, 32'h1234_5679, 30'h0000_0010, 3'h1);
    ev(0, 1'b1, 32'hffff_ffff, 30'h2aaa_aaaa, 3'h4);
    ev(0, 1'b0, 32'h0bad_0bad, 30'h0155_0155, 3'h0);
    ev(1, 1'b1, 32'h0000_0001, 30'h0000_0001, 3'h0);
    ev(1, 1'b0, 32'h8000_0000, 30'h1555_5555, 3'h3);
    ev(1, 1'b1, 32'h0000_0007, 30'h0000_0008, 3'h7);
    // Fourteen more unit 1 edges drive its count into saturation; its slots stay put
    for (int i = 0; i < 14; i++)
      ev(1, i[0], 32'h0bad_0000, 30'h0000_0bad, 3'h1);
    unit0_slots();
    // Width of the first unit 0 pulse, modulo the 30-bit field, is 0x20 ns
    rd(ETSR_SAMPLE1_NS_OFFSET, 32'h7fff_fff0);
    first_word = reg_rdata;
    rd(ETSR_SAMPLE2_NS_OFFSET, 32'h0000_0010);
    chk("width ns", 32'h20, {2'b00, 30'(reg_rdata[29:0] - first_word[29:0])});
    wr(ETSR_SAMPLE1_SEC_OFFSET, 32'hdead_beef);
    wr(ETSR_SAMPLE1_NS_OFFSET, 32'hffff_ffff);
    wr(ETSR_SAMPLE2_PHASE_OFFSET, 32'h0000_0007);
    wr(ETSR_SAMPLE3_NS_OFFSET, 32'h1234_0000);
    unit0_slots();
    wr(ETSR_UNIT_INDEX_OFFSET, 32'h0000_0100);
    #1;
    chk("unit_ptr", 32'h1, {31'h0, unit_ptr});
    rd(ETSR_UNIT_INDEX_OFFSET, 32'h0000_0100);
    slot(0, 32'h0000_0001, 30'h0000_0001, 1'b1, 3'h0);
    slot(1, 32'h8000_0000, 30'h1555_5555, 1'b0, 3'h3);
    slot(2, 32'h0000_0007, 30'h0000_0008, 1'b1, 3'h4);
    rd(16'h0600, 32'h0);
    wr(ETSR_UNIT_INDEX_OFFSET, 32'h0000_0000);
    slot(0, 32'h1234_5678, 30'h3fff_fff0, 1'b1, 3'h2);
    wr(ETSR_UNIT_INDEX_OFFSET, 32'h0000_0100);
    // Reset in mid-run clears every stored sample and the pointer
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    event_in <= '0;
    #1;
    chk("unit_ptr", 32'h0, {31'h0, unit_ptr});
    slot(0, 32'h0, 30'h0, 1'b0, 3'h0);
    slot(2, 32'h0, 30'h0, 1'b0, 3'h0);
    // Slots refill from the first; the third edge lands in the 16 ns sub-slot
    ev(0, 1'b1, 32'h0000_0100, 30'h0000_0200, 3'h4);
    ev(0, 1'b0, 32'h0000_0101, 30'h0000_0300, 3'h0);
    ev(0, 1'b1, 32'h0000_0102, 30'h0000_0400, 3'h2);
    slot(0, 32'h0000_0100, 30'h0000_0200, 1'b1, 3'h4);
    slot(2, 32'h0000_0102, 30'h0000_0400, 1'b1, 3'h2);
    print_verdict();
  end
endmodule // etsr_sample_regs_tb_top
